/* include/ipsc_defines.vh */
// Constants of the image port stream coder: offsets, fields, reset values, code bytes
`ifndef IPSC_DEFINES_VH
`define IPSC_DEFINES_VH

// Register byte offsets
`define IPSC_OFS_CTRL 8'h00
`define IPSC_OFS_SLICE 8'h04
`define IPSC_OFS_MAP 8'h08
`define IPSC_OFS_STATUS 8'h0C

// Writable masks and reset values
`define IPSC_CTRL_MASK 32'h0000_000F
`define IPSC_SLICE_MASK 32'h003F_3F3F
`define IPSC_MAP_MASK 32'h000F_FFFF
`define IPSC_CTRL_RST 32'h0000_0001
`define IPSC_SLICE_RST 32'h0000_0000
`define IPSC_MAP_RST 32'h0004_3210

// Control fields
`define IPSC_CTRL_CODES_ON 0
`define IPSC_CTRL_TRIG_MODE 1
`define IPSC_CTRL_PAGE_A 2
`define IPSC_CTRL_PAGE_B 3

// Sliced data identifier values that select start/end code framing, and the fixed data count
`define IPSC_DID_SAV_MSB1 6'h3E
`define IPSC_DID_SAV_MSB0 6'h3F
`define IPSC_DC_FIXED 6'h0B

// Stream bytes
`define IPSC_BYTE_ONES 8'hFF
`define IPSC_BYTE_ZERO 8'h00

// Code bytes, index {msb, kind[1:0], field}
`define IPSC_CODE_0 8'h0E
`define IPSC_CODE_1 8'h49
`define IPSC_CODE_2 8'h13
`define IPSC_CODE_3 8'h54
`define IPSC_CODE_4 8'h25
`define IPSC_CODE_5 8'h62
`define IPSC_CODE_6 8'h38
`define IPSC_CODE_7 8'h7F
`define IPSC_CODE_8 8'h80
`define IPSC_CODE_9 8'hC7
`define IPSC_CODE_A 8'h9D
`define IPSC_CODE_B 8'hDA
`define IPSC_CODE_C 8'hAB
`define IPSC_CODE_D 8'hEC
`define IPSC_CODE_E 8'hB6
`define IPSC_CODE_F 8'hF1

// AXI responses
`define IPSC_RESP_OKAY 2'b00
`define IPSC_RESP_SLVERR 2'b10

`endif

/* rtl/ipsc_stream_coder.v */
// Image port stream coder: framing, reference codes, qualifier and flag mapping
`timescale 1ns/1ps
`include "ipsc_defines.vh"

module ipsc_stream_coder
(
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  // AXI4-Lite register slave
  input wire [7:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [7:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // Scaled video byte stream
  input wire i_vid_valid,
  input wire [7:0] i_vid_data,
  input wire i_vid_eol,
  input wire i_vid_blank,
  input wire i_vid_last_line,
  input wire i_vid_field,
  input wire i_vid_task_b,
  output wire o_vid_ready,
  // Sliced data byte stream
  input wire i_slc_valid,
  input wire [7:0] i_slc_data,
  input wire i_slc_last,
  input wire i_slc_field,
  input wire [7:0] i_slc_identification_byte_one,
  input wire [7:0] i_slc_identification_byte_two,
  output wire o_slc_ready,
  // Image port
  input wire i_port_hold_input,
  output reg [7:0] o_port_data,
  output wire o_port_data_qualifier,
  output wire o_port_horizontal_ref_out,
  output wire o_port_vertical_ref_out,
  output wire o_port_flag_out_a,
  output wire o_port_flag_out_b
);

  localparam ST_IDLE = 4'd0;
  localparam ST_SPRE = 4'd1;
  localparam ST_SCODE = 4'd2;
  localparam ST_VPAY = 4'd3;
  localparam ST_AHDR = 4'd4;
  localparam ST_SHDR = 4'd5;
  localparam ST_SPAY = 4'd6;
  localparam ST_STRL = 4'd7;
  localparam ST_EPRE = 4'd8;
  localparam ST_ECODE = 4'd9;

  // Header byte: not-even-parity, even-parity, six value bits
  function [7:0] ipsc_parity_byte;
    input [5:0] v;
    begin
      ipsc_parity_byte = {~^v, ^v, v};
    end
  endfunction

  function [7:0] ipsc_code;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: ipsc_code = `IPSC_CODE_0;
        4'h1: ipsc_code = `IPSC_CODE_1;
        4'h2: ipsc_code = `IPSC_CODE_2;
        4'h3: ipsc_code = `IPSC_CODE_3;
        4'h4: ipsc_code = `IPSC_CODE_4;
        4'h5: ipsc_code = `IPSC_CODE_5;
        4'h6: ipsc_code = `IPSC_CODE_6;
        4'h7: ipsc_code = `IPSC_CODE_7;
        4'h8: ipsc_code = `IPSC_CODE_8;
        4'h9: ipsc_code = `IPSC_CODE_9;
        4'hA: ipsc_code = `IPSC_CODE_A;
        4'hB: ipsc_code = `IPSC_CODE_B;
        4'hC: ipsc_code = `IPSC_CODE_C;
        4'hD: ipsc_code = `IPSC_CODE_D;
        4'hE: ipsc_code = `IPSC_CODE_E;
        default: ipsc_code = `IPSC_CODE_F;
      endcase
    end
  endfunction

  function [31:0] ipsc_merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] strb;
    input [31:0] mask;
    integer k;
    begin
      ipsc_merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          ipsc_merge[k*8 +: 8] = wdat[k*8 +: 8];
      ipsc_merge = ipsc_merge & mask;
    end
  endfunction

  // Selected event with polarity applied
  function ipsc_map;
    input [7:0] ev;
    input [3:0] fld;
    begin
      ipsc_map = ev[fld[2:0]] ^ fld[3];
    end
  endfunction

  // Registers
  reg [31:0] reg_ctrl;
  reg [31:0] reg_slice;
  reg [31:0] reg_map;

  // Bus slave state
  reg aw_got;
  reg w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // Coder state
  reg [3:0] state;
  reg [1:0] cnt;
  reg is_slice;
  reg anc_mode;
  reg ln_blank;
  reg ln_last;
  reg ln_field;
  reg ln_msb;
  reg [7:0] ln_identification_byte_one;
  reg [7:0] ln_identification_byte_two;
  reg [7:0] csum;
  reg [7:0] bcnt;
  reg out_qual;
  reg h_gate;
  reg v_gate;
  reg h_trig;
  reg v_trig;
  reg slc_flag;

  reg [3:0] next_state;
  reg [1:0] next_cnt;
  reg [7:0] next_data;
  reg next_qual;
  reg sav_now;
  reg line_end;
  reg anc_start;
  reg take_vid;
  reg take_slc;
  reg start_vid;
  reg start_slc;
  reg next_h_gate;
  reg next_v_gate;

  wire hold = i_port_hold_input;
  wire codes_on = reg_ctrl[`IPSC_CTRL_CODES_ON];
  wire [5:0] sliced_data_identifier = reg_slice[5:0];
  wire [5:0] sliced_source_id_byte = reg_slice[13:8];
  wire [5:0] anc_dc = reg_slice[21:16];
  wire did_anc = sliced_data_identifier < `IPSC_DID_SAV_MSB1;
  wire [1:0] sav_kind = ln_blank ? 2'd2 : 2'd0;
  wire [1:0] eav_kind = (ln_blank | ln_last) ? 2'd3 : 2'd1;

  assign o_vid_ready = (state == ST_VPAY) & ~hold;
  assign o_slc_ready = (state == ST_SPAY) & ~hold;

  // Byte sequencer; every held cycle emits 00h with qualifier low
  always @*
  begin
    next_state = state;
    next_cnt = cnt;
    next_data = `IPSC_BYTE_ZERO;
    next_qual = 1'b0;
    sav_now = 1'b0;
    line_end = 1'b0;
    anc_start = 1'b0;
    take_vid = 1'b0;
    take_slc = 1'b0;
    start_vid = 1'b0;
    start_slc = 1'b0;
    if (!hold)
    begin
      case (state)
        ST_IDLE:
        begin
          next_cnt = 2'd0;
          if (i_slc_valid)
          begin
            start_slc = 1'b1;
            if (!codes_on)
              next_state = ST_SHDR;
            else if (did_anc)
              next_state = ST_AHDR;
            else
              next_state = ST_SPRE;
          end
          else if (i_vid_valid)
          begin
            start_vid = 1'b1;
            next_state = codes_on ? ST_SPRE : ST_VPAY;
          end
        end
        ST_SPRE, ST_EPRE:
        begin
          next_data = (cnt == 2'd0) ? `IPSC_BYTE_ONES : `IPSC_BYTE_ZERO;
          next_qual = 1'b1;
          next_cnt = cnt + 2'd1;
          if (cnt == 2'd2)
          begin
            next_cnt = 2'd0;
            next_state = (state == ST_SPRE) ? ST_SCODE : ST_ECODE;
          end
        end
        ST_SCODE:
        begin
          next_data = ipsc_code({ln_msb, sav_kind, ln_field});
          next_qual = 1'b1;
          sav_now = 1'b1;
          next_state = is_slice ? ST_SHDR : ST_VPAY;
        end
        ST_VPAY:
        begin
          if (i_vid_valid)
          begin
            take_vid = 1'b1;
            next_data = i_vid_data;
            next_qual = 1'b1;
            if (i_vid_eol)
            begin
              next_state = codes_on ? ST_EPRE : ST_IDLE;
              line_end = ~codes_on;
            end
          end
        end
        ST_AHDR:
        begin
          case (cnt)
            2'd0: next_data = `IPSC_BYTE_ZERO;
            2'd1: next_data = `IPSC_BYTE_ONES;
            2'd2: next_data = `IPSC_BYTE_ONES;
            default: next_data = ipsc_parity_byte(sliced_data_identifier);
          endcase
          next_qual = 1'b1;
          anc_start = (cnt == 2'd0);
          next_cnt = cnt + 2'd1;
          if (cnt == 2'd3)
            next_state = ST_SHDR;
        end
        ST_SHDR:
        begin
          case (cnt)
            2'd0: next_data = ipsc_parity_byte(sliced_source_id_byte);
            2'd1: next_data = ipsc_parity_byte(anc_mode ? anc_dc : `IPSC_DC_FIXED);
            2'd2: next_data = ln_identification_byte_one;
            default: next_data = ln_identification_byte_two;
          endcase
          next_qual = 1'b1;
          next_cnt = cnt + 2'd1;
          if (cnt == 2'd3)
            next_state = ST_SPAY;
        end
        ST_SPAY:
        begin
          if (i_slc_valid)
          begin
            take_slc = 1'b1;
            next_data = i_slc_data;
            next_qual = 1'b1;
            if (i_slc_last)
            begin
              next_cnt = 2'd0;
              next_state = ST_STRL;
            end
          end
        end
        ST_STRL:
        begin
          next_data = (cnt == 2'd0) ? csum : bcnt;
          next_qual = 1'b1;
          next_cnt = cnt + 2'd1;
          if (cnt == 2'd1)
          begin
            next_cnt = 2'd0;
            if (codes_on && !anc_mode)
              next_state = ST_EPRE;
            else
            begin
              next_state = ST_IDLE;
              line_end = 1'b1;
            end
          end
        end
        ST_ECODE:
        begin
          next_data = ipsc_code({ln_msb, eav_kind, ln_field});
          next_qual = 1'b1;
          line_end = 1'b1;
          next_state = ST_IDLE;
        end
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  // Gate registers the state whose byte leaves at the same edge, so it
  // lines up with the payload bytes; vertical gate spans active lines
  always @*
  begin
    next_h_gate = (state == ST_VPAY) || (state == ST_SHDR) ||
      (state == ST_SPAY) || (state == ST_STRL);
    next_v_gate = v_gate;
    if (sav_now && !is_slice && !ln_blank)
      next_v_gate = 1'b1;
    if (start_vid && !codes_on && !i_vid_blank)
      next_v_gate = 1'b1;
    if (line_end && (ln_blank || ln_last))
      next_v_gate = 1'b0;
  end

  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      state <= ST_IDLE;
      cnt <= 2'd0;
      is_slice <= 1'b0;
      anc_mode <= 1'b0;
      ln_blank <= 1'b0;
      ln_last <= 1'b0;
      ln_field <= 1'b0;
      ln_msb <= 1'b0;
      ln_identification_byte_one <= 8'h00;
      ln_identification_byte_two <= 8'h00;
      csum <= 8'h00;
      bcnt <= 8'h00;
      o_port_data <= 8'h00;
      out_qual <= 1'b0;
      h_gate <= 1'b0;
      v_gate <= 1'b0;
      h_trig <= 1'b0;
      v_trig <= 1'b0;
      slc_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      o_port_data <= next_data;
      out_qual <= next_qual;
      h_gate <= next_h_gate;
      v_gate <= next_v_gate;
      h_trig <= next_h_gate & ~h_gate;
      v_trig <= next_v_gate & ~v_gate;
      if (start_vid)
      begin
        is_slice <= 1'b0;
        anc_mode <= 1'b0;
        ln_blank <= i_vid_blank;
        ln_last <= i_vid_last_line;
        ln_field <= i_vid_field;
        ln_msb <= i_vid_task_b ? ~reg_ctrl[`IPSC_CTRL_PAGE_B] :
          ~reg_ctrl[`IPSC_CTRL_PAGE_A];
      end
      if (start_slc)
      begin
        is_slice <= 1'b1;
        anc_mode <= did_anc;
        ln_blank <= 1'b1;
        ln_last <= 1'b0;
        ln_field <= i_slc_field;
        ln_msb <= (sliced_data_identifier == `IPSC_DID_SAV_MSB1);
        ln_identification_byte_one <= i_slc_identification_byte_one;
        ln_identification_byte_two <= i_slc_identification_byte_two;
        csum <= 8'h00;
        bcnt <= 8'h00;
      end
      if (take_slc)
      begin
        csum <= csum + i_slc_data;
        bcnt <= bcnt + 8'h01;
      end
      if (anc_start)
        slc_flag <= 1'b1;
      else if (sav_now)
        slc_flag <= 1'b0;
    end
  end

  // Output mapping: 0 qualifier, 1 h ref, 2 v ref, 3 sliced flag,
  // 4 h gate, 5 v gate, 6 h trigger, 7 v trigger
  wire trig_mode = reg_ctrl[`IPSC_CTRL_TRIG_MODE];
  wire [7:0] events = {v_trig, h_trig, v_gate, h_gate, slc_flag,
    trig_mode ? v_trig : v_gate, trig_mode ? h_trig : h_gate, out_qual};

  assign o_port_data_qualifier = ipsc_map(events, reg_map[3:0]);
  assign o_port_horizontal_ref_out = ipsc_map(events, reg_map[7:4]);
  assign o_port_vertical_ref_out = ipsc_map(events, reg_map[11:8]);
  assign o_port_flag_out_a = ipsc_map(events, reg_map[15:12]);
  assign o_port_flag_out_b = ipsc_map(events, reg_map[19:16]);

  // AXI4-Lite slave, one write and one read at a time
  assign o_s_axi_awready = ~aw_got & ~o_s_axi_bvalid;
  assign o_s_axi_wready = ~w_got & ~o_s_axi_bvalid;
  assign o_s_axi_arready = ~o_s_axi_rvalid;

  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `IPSC_RESP_OKAY;
      reg_ctrl <= `IPSC_CTRL_RST;
      reg_slice <= `IPSC_SLICE_RST;
      reg_map <= `IPSC_MAP_RST;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_got <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (aw_got && w_got)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= `IPSC_RESP_OKAY;
        if (aw_addr == `IPSC_OFS_CTRL)
          reg_ctrl <= ipsc_merge(reg_ctrl, w_data, w_strb, `IPSC_CTRL_MASK);
        else if (aw_addr == `IPSC_OFS_SLICE)
          reg_slice <= ipsc_merge(reg_slice, w_data, w_strb, `IPSC_SLICE_MASK);
        else if (aw_addr == `IPSC_OFS_MAP)
          reg_map <= ipsc_merge(reg_map, w_data, w_strb, `IPSC_MAP_MASK);
        else if (aw_addr != `IPSC_OFS_STATUS)
          o_s_axi_bresp <= `IPSC_RESP_SLVERR;
      end
      else if (o_s_axi_bvalid && i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= `IPSC_RESP_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp <= `IPSC_RESP_OKAY;
      if (i_s_axi_araddr == `IPSC_OFS_CTRL)
        o_s_axi_rdata <= reg_ctrl;
      else if (i_s_axi_araddr == `IPSC_OFS_SLICE)
        o_s_axi_rdata <= reg_slice;
      else if (i_s_axi_araddr == `IPSC_OFS_MAP)
        o_s_axi_rdata <= reg_map;
      else if (i_s_axi_araddr == `IPSC_OFS_STATUS)
        o_s_axi_rdata <= {24'h00_0000, state, hold, v_gate, h_gate, slc_flag};
      else
      begin
        o_s_axi_rdata <= 32'h0000_0000;
        o_s_axi_rresp <= `IPSC_RESP_SLVERR;
      end
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
      o_s_axi_rvalid <= 1'b0;
  end

endmodule // ipsc_stream_coder

/* verif/ipsc_chk.sv */
// Port checker for the image port stream coder
`timescale 1ns/1ps
module ipsc_chk
(
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  // Register bus
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid,
  // Streams
  input wire i_vid_valid,
  input wire [7:0] i_vid_data,
  input wire o_vid_ready,
  input wire i_slc_valid,
  input wire [7:0] i_slc_data,
  input wire o_slc_ready,
  // Image port
  input wire i_port_hold_input,
  input wire [7:0] o_port_data,
  input wire o_port_data_qualifier,
  input wire o_port_horizontal_ref_out,
  input wire o_port_vertical_ref_out,
  input wire o_port_flag_out_a
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  property p_zero;
    o_port_data != 8'h00 |-> o_port_data_qualifier;
  endproperty
  a_zero: assert property (p_zero) else $error("data byte without qualifier");
  property p_hold_zero;
    i_port_hold_input |=> o_port_data == 8'h00;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("data while held");
  property p_stall;
    i_port_hold_input |-> !o_vid_ready && !o_slc_ready;
  endproperty
  a_stall: assert property (p_stall) else $error("ready while held");
  property p_vid;
    i_vid_valid && o_vid_ready |=> o_port_data_qualifier && o_port_data == $past(i_vid_data);
  endproperty
  a_vid: assert property (p_vid) else $error("video byte not passed");
  property p_slc;
    i_slc_valid && o_slc_ready |=> o_port_data_qualifier && o_port_data == $past(i_slc_data);
  endproperty
  a_slc: assert property (p_slc) else $error("sliced byte not passed");
  property p_pre;
    o_port_data_qualifier && o_port_data == 8'hFF && !o_port_flag_out_a
      |=> o_port_data == 8'h00 [*2];
  endproperty
  a_pre: assert property (p_pre) else $error("preamble broken");
  property p_rst;
    disable iff (1'b0)
    !i_rst_b |=> !o_port_data_qualifier && !o_port_horizontal_ref_out
      && !o_port_vertical_ref_out && o_port_data == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_bdone;
    o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write response repeated");
  property p_rans;
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  c_hold: cover property (i_port_hold_input ##1 o_vid_ready);
  c_slc: cover property (i_slc_valid && o_slc_ready);
  c_vid: cover property (i_vid_valid && o_vid_ready ##1 o_port_horizontal_ref_out);
endmodule // ipsc_chk

bind ipsc_stream_coder ipsc_chk u_chk
(
  .i_ref_clk,
  .i_rst_b,
  .o_s_axi_bvalid,
  .i_s_axi_bready,
  .i_s_axi_arvalid,
  .o_s_axi_arready,
  .o_s_axi_rvalid,
  .i_vid_valid,
  .i_vid_data,
  .o_vid_ready,
  .i_slc_valid,
  .i_slc_data,
  .o_slc_ready,
  .i_port_hold_input,
  .o_port_data,
  .o_port_data_qualifier,
  .o_port_horizontal_ref_out,
  .o_port_vertical_ref_out,
  .o_port_flag_out_a
);

/* verif/ipsc_capture_model.sv */
// Capture side model: stores qualified bytes and drives the hold input
`timescale 1ns/1ps
module ipsc_capture_model
(
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  // Image port
  input wire [7:0] i_port_data,
  input wire i_port_data_qualifier,
  input wire i_port_horizontal_ref_out,
  output reg o_port_hold_input = 1'b0,
  // Bench control
  input wire i_stall,
  input wire i_clear
);
  reg [7:0] mem [0:63];
  reg [7:0] n;
  reg [7:0] nh;
  reg [1:0] ph;
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b || i_clear)
    begin
      n <= 8'h00;
      nh <= 8'h00;
      ph <= 2'b00;
      o_port_hold_input <= 1'b0;
    end
    else
    begin
      ph <= ph + 2'd1;
      // Two held cycles out of four while stalling
      o_port_hold_input <= i_stall & ph[1];
      // Stored only when qualified; no fixed delay assumed
      if (i_port_data_qualifier)
      begin
        mem[n[5:0]] <= i_port_data;
        n <= n + 8'h01;
      end
      if (i_port_horizontal_ref_out)
        nh <= nh + 8'h01;
    end
  end
endmodule // ipsc_capture_model

/* verif/image_port_stream_coder_tb_top.sv */
// Self-checking bench for the image port stream coder
`timescale 1ns/1ps
module image_port_stream_coder_tb_top;
  reg i_ref_clk = 1'b0;
  reg i_rst_b = 1'b0;
  reg [7:0] i_s_axi_awaddr = 8'h00;
  reg i_s_axi_awvalid = 1'b0;
  reg [31:0] i_s_axi_wdata = 32'h0000_0000;
  reg [3:0] i_s_axi_wstrb = 4'hF;
  reg i_s_axi_wvalid = 1'b0;
  reg i_s_axi_bready = 1'b0;
  reg [7:0] i_s_axi_araddr = 8'h00;
  reg i_s_axi_arvalid = 1'b0;
  reg i_s_axi_rready = 1'b0;
  reg i_vid_valid = 1'b0;
  reg [7:0] i_vid_data = 8'h00;
  reg i_vid_eol = 1'b0;
  reg i_vid_blank = 1'b0;
  reg i_vid_last_line = 1'b0;
  reg i_vid_field = 1'b0;
  reg i_vid_task_b = 1'b0;
  reg i_slc_valid = 1'b0;
  reg [7:0] i_slc_data = 8'h00;
  reg i_slc_last = 1'b0;
  reg i_slc_field = 1'b0;
  reg [7:0] i_slc_identification_byte_one = 8'h21;
  reg [7:0] i_slc_identification_byte_two = 8'h22;
  reg stall = 1'b0;
  reg clear = 1'b0;
  reg con = 1'b1;
  reg m, f, sel;
  integer ty, i, j;
  integer n_mismatch = 0;
  integer checks = 0;
  reg [7:0] exq [$];
  localparam logic [7:0] CODE [0:15] = '{8'h0E, 8'h49, 8'h13, 8'h54, 8'h25, 8'h62,
    8'h38, 8'h7F, 8'h80, 8'hC7, 8'h9D, 8'hDA, 8'hAB, 8'hEC, 8'hB6, 8'hF1};
  wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0] o_s_axi_rdata;
  wire o_vid_ready, o_slc_ready, i_port_hold_input;
  wire [7:0] o_port_data;
  wire o_port_data_qualifier, o_port_horizontal_ref_out, o_port_vertical_ref_out;
  wire o_port_flag_out_a, o_port_flag_out_b;

  ipsc_stream_coder dut
  (
    .i_ref_clk, .i_rst_b,
    .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
    .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
    .i_vid_valid, .i_vid_data, .i_vid_eol, .i_vid_blank, .i_vid_last_line,
    .i_vid_field, .i_vid_task_b, .o_vid_ready,
    .i_slc_valid, .i_slc_data, .i_slc_last, .i_slc_field,
    .i_slc_identification_byte_one, .i_slc_identification_byte_two, .o_slc_ready,
    .i_port_hold_input, .o_port_data, .o_port_data_qualifier,
    .o_port_horizontal_ref_out, .o_port_vertical_ref_out,
    .o_port_flag_out_a, .o_port_flag_out_b
  );

  ipsc_capture_model cap
  (
    .i_ref_clk, .i_rst_b,
    .i_port_data(o_port_data),
    .i_port_data_qualifier(o_port_data_qualifier),
    .i_port_horizontal_ref_out(o_port_horizontal_ref_out),
    .o_port_hold_input(i_port_hold_input),
    .i_stall(stall),
    .i_clear(clear)
  );

  initial
  begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  task stop_hung;
  begin
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    tally_and_finish;
  end
  endtask

  task chk(input [31:0] g, input [31:0] e);
  begin
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask

  function [7:0] hdr(input [5:0] v);
    hdr = {~^v, ^v, v};
  endfunction

  task wr(input [7:0] a, input [31:0] d);
    integer t;
    reg ta, tw, tb;
    reg [1:0] rsp;
  begin
    tb = 1'b0;
    @(posedge i_ref_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    for (t = 0; t < 50 && !tb; t++)
    begin
      @(negedge i_ref_clk);
      ta = i_s_axi_awvalid && o_s_axi_awready;
      tw = i_s_axi_wvalid && o_s_axi_wready;
      tb = o_s_axi_bvalid;
      rsp = o_s_axi_bresp;
      @(posedge i_ref_clk);
      if (ta)
        i_s_axi_awvalid <= 1'b0;
      if (tw)
        i_s_axi_wvalid <= 1'b0;
    end
    i_s_axi_bready <= 1'b0;
    if (!tb)
      stop_hung;
    chk(rsp, 0);
  end
  endtask

  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    integer t;
    reg tr, ta;
  begin
    tr = 1'b0;
    @(posedge i_ref_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    for (t = 0; t < 50 && !tr; t++)
    begin
      @(negedge i_ref_clk);
      ta = i_s_axi_arvalid && o_s_axi_arready;
      tr = o_s_axi_rvalid;
      if (tr)
      begin
        chk(o_s_axi_rdata, ed);
        chk(o_s_axi_rresp, er);
      end
      @(posedge i_ref_clk);
      if (ta)
        i_s_axi_arvalid <= 1'b0;
    end
    i_s_axi_rready <= 1'b0;
    if (!tr)
      stop_hung;
  end
  endtask

  task push4(input [7:0] c);
  begin
    if (con)
    begin
      exq.push_back(8'hFF);
      exq.push_back(8'h00);
      exq.push_back(8'h00);
      exq.push_back(c);
    end
  end
  endtask

  task send(input s, input [7:0] n, input [7:0] b);
    integer k, t;
    reg tk;
  begin
    for (k = 0; k < n; k++)
      exq.push_back(b + k[7:0]);
    k = 0;
    i_vid_data <= b;
    i_slc_data <= b;
    i_vid_eol <= (n == 1);
    i_slc_last <= (n == 1);
    i_vid_valid <= !s;
    i_slc_valid <= s;
    for (t = 0; t < 300 && k < n; t++)
    begin
      @(negedge i_ref_clk);
      tk = s ? o_slc_ready : o_vid_ready;
      @(posedge i_ref_clk);
      if (tk)
      begin
        k++;
        i_vid_data <= b + k[7:0];
        i_slc_data <= b + k[7:0];
        i_vid_eol <= (k == n - 1);
        i_slc_last <= (k == n - 1);
        if (k == n)
        begin
          i_vid_valid <= 1'b0;
          i_slc_valid <= 1'b0;
        end
      end
    end
    if (k < n)
      stop_hung;
  end
  endtask

  task cmpq(input integer eh);
    integer t, k;
  begin
    for (t = 0; t < 400 && cap.n < exq.size(); t++)
      @(posedge i_ref_clk);
    if (t == 400)
      stop_hung;
    repeat (4) @(posedge i_ref_clk);
    chk(cap.n, exq.size());
    for (k = 0; k < exq.size(); k++)
      chk(cap.mem[k], exq[k]);
    if (eh >= 0)
      chk(cap.nh, eh);
    exq.delete();
    clear <= 1'b1;
    @(posedge i_ref_clk);
    clear <= 1'b0;
  end
  endtask

  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rd(8'h00, 32'h0000_0001, 2'b00);
    rd(8'h08, 32'h0004_3210, 2'b00);
    rd(8'h10, 32'h0000_0000, 2'b10);
    $display("test reset values done");
    for (i = 0; i < 12; i++)
    begin
      m = i[0];
      f = i[1];
      sel = i[2];
      ty = i / 4;
      // Only the selected task's page bit decides the code top bit
      wr(8'h00, {28'h000_0000, sel ? ~m : m, sel ? m : ~m, 2'b01});
      i_vid_field <= f;
      i_vid_task_b <= sel;
      i_vid_blank <= (ty == 2);
      i_vid_last_line <= (ty == 1);
      push4(CODE[{m, ty == 2, 1'b0, f}]);
      send(1'b0, 8'd2, 8'h40 + i[7:0]);
      push4(CODE[{m, ty != 0, 1'b1, f}]);
      cmpq(2);
      chk(o_port_vertical_ref_out, ty == 0);
    end
    $display("test reference codes done");
    wr(8'h00, 32'h0000_0003);
    i_vid_blank <= 1'b0;
    i_vid_last_line <= 1'b0;
    i_vid_field <= 1'b0;
    i_vid_task_b <= 1'b0;
    stall <= 1'b1;
    push4(8'h80);
    send(1'b0, 8'd6, 8'h50);
    push4(8'h9D);
    cmpq(1);
    stall <= 1'b0;
    wr(8'h00, 32'h0000_0000);
    con = 1'b0;
    send(1'b0, 8'd3, 8'h60);
    cmpq(3);
    con = 1'b1;
    $display("test trigger hold and no codes done");
    wr(8'h00, 32'h0000_0001);
    wr(8'h04, 32'h0002_0510);
    exq.push_back(8'h00);
    exq.push_back(8'hFF);
    exq.push_back(8'hFF);
    exq.push_back(hdr(6'h10));
    exq.push_back(hdr(6'h05));
    exq.push_back(hdr(6'h02));
    exq.push_back(8'h21);
    exq.push_back(8'h22);
    send(1'b1, 8'd3, 8'h30);
    exq.push_back(8'h93);
    exq.push_back(8'h03);
    cmpq(-1);
    chk(o_port_flag_out_a, 1);
    for (j = 0; j < 2; j++)
    begin
      wr(8'h04, 32'h0000_053E + j);
      i_slc_field <= j[0];
      i_slc_identification_byte_one <= 8'h21 + j[7:0];
      i_slc_identification_byte_two <= 8'h22 + j[7:0];
      push4(CODE[{~j[0], 2'b10, j[0]}]);
      exq.push_back(hdr(6'h05));
      exq.push_back(8'h4B);
      exq.push_back(8'h21 + j[7:0]);
      exq.push_back(8'h22 + j[7:0]);
      send(1'b1, 8'd3, 8'h30);
      exq.push_back(8'h93);
      exq.push_back(8'h03);
      push4(CODE[{~j[0], 2'b11, j[0]}]);
      cmpq(-1);
      chk(o_port_flag_out_a, 0);
    end
    $display("test sliced lines done");
    wr(8'h08, 32'h000C_3218);
    repeat (2) @(negedge i_ref_clk);
    chk(o_port_data_qualifier, 1);
    chk(o_port_flag_out_b, 1);
    chk(o_port_data, 0);
    rd(8'h08, 32'h000C_3218, 2'b00);
    i_s_axi_wstrb <= 4'h1;
    wr(8'h08, 32'hFFFF_FF10);
    rd(8'h08, 32'h000C_3210, 2'b00);
    $display("test polarity map done");
    tally_and_finish;
  end
endmodule // image_port_stream_coder_tb_top
